// ---- scmc_top.sv ----
// System clock selection and low-power mode control with APB registers
// Contract
// - Divider code picks slow or fast divided
// - High select gives undivided fast clock
// - Fast oscillator stops when slow chosen
// - Slow ready flag rises 1-2 cycles
// - Fast ready low in sleep/idle0, 15-16 cycles
// - Halt with idle off enters sleep
// - Idle on, keep off enters idle0
// - Idle on, keep on enters idle1
// - Sleep stops system and time-base clocks
// - Halt entry clears watchdog counter
// - Halt entry sets power-down, clears expiry
// - Halted modes preserve registers and state
// - Frequency field sets fast RC frequency
// - Divided fast sources stop with oscillator
// - Unimplemented bits read zero
// - Wake to fast waits fast ready
`include "scmc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module scmc_top (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic [31:0]      PRDATA,
    // CPU halt and wake
    input  wire logic        HALT_EXEC,
    input  wire logic        WAKE_UP,
    output logic             CPU_RUN,
    // Clock enables
    output logic             SYS_CLK_EN,
    output logic             TIMEBASE_CLK_EN,
    output logic             FAST_OSC_ON,
    output logic [1:0]       FAST_RC_FREQ,
    output logic             FAST_DIV16_EN,
    output logic             FAST_DIV64_EN,
    // Watchdog and status flags
    output logic             WDT_CLEAR,
    output logic             POWER_DOWN_FLAG,
    output logic             WDT_EXPIRY_FLAG,
    input  wire logic        WDT_EXPIRY_SET,
    input  wire logic        CLR_WDT_EXEC
);
    logic [2:0]             clk_divide_select_q, clk_divide_select_d;
    logic                   high_clk_select_q, high_clk_select_d;
    logic                   halt_low_power_select_q, halt_low_power_select_d;
    logic                   keep_clock_in_halt_q, keep_clock_in_halt_d;
    logic [1:0]             fast_rc_freq_select_q, fast_rc_freq_select_d;
    scmc_pkg::scmc_mode_t   mode_q, mode_d;
    logic [4:0]             slow_cnt_q, slow_cnt_d;
    logic [4:0]             fast_cnt_q, fast_cnt_d;
    logic                   pdf_q, pdf_d;
    logic                   to_q, to_d;
    logic                   wdt_clr_q, wdt_clr_d;
    logic [31:0]            prdata_q, prdata_d;
    logic                   sys_en_q, sys_en_d;
    logic [5:0]             tick;
    logic                   slow_osc_ready, fast_osc_ready, fast_sel, fast_on, wr, rd;
    logic                   halt_go;

    function automatic logic sel_fast(input logic hs, input logic [2:0] dv);
        sel_fast = hs | (dv[2] | dv[1]);
    endfunction : sel_fast

    assign wr = PSEL & PENABLE & PWRITE;
    assign rd = PSEL & !PENABLE & !PWRITE;
    assign PREADY = 1'b1;
    assign PSLVERR = 1'b0;
    assign halt_go = HALT_EXEC & (mode_q == scmc_pkg::SCMC_RUN);
    assign slow_osc_ready = (slow_cnt_q >= `SCMC_SLOW_RDY_CYC);
    assign fast_osc_ready = (fast_cnt_q >= `SCMC_FAST_RDY_CYC);
    assign fast_sel = sel_fast(high_clk_select_q, clk_divide_select_q);
    // Oscillator off in slow mode and in sleep/idle0; idle1 keeps whichever runs
    assign fast_on = fast_sel & ((mode_q == scmc_pkg::SCMC_RUN)
                     | (mode_q == scmc_pkg::SCMC_IDLE1));

    // Registers: writes only in run; halted modes hold all state
    always_comb begin
        clk_divide_select_d = clk_divide_select_q;
        high_clk_select_d = high_clk_select_q;
        halt_low_power_select_d = halt_low_power_select_q;
        keep_clock_in_halt_d = keep_clock_in_halt_q;
        fast_rc_freq_select_d = fast_rc_freq_select_q;
        if (wr && PADDR == `SCMC_SYS_MODE_REG_OFS && mode_q == scmc_pkg::SCMC_RUN) begin
            clk_divide_select_d = PWDATA[`SCMC_SYS_MODE_REG_DIV_MSB:`SCMC_SYS_MODE_REG_DIV_LSB];
            halt_low_power_select_d = PWDATA[`SCMC_SYS_MODE_REG_IDLE_EN];
            high_clk_select_d = PWDATA[`SCMC_SYS_MODE_REG_HIGH_SEL];
        end
        if (wr && PADDR == `SCMC_CTRL_OFS && mode_q == scmc_pkg::SCMC_RUN) begin
            keep_clock_in_halt_d = PWDATA[`SCMC_CTRL_KEEP_CLK];
            fast_rc_freq_select_d = PWDATA[`SCMC_CTRL_FREQ_MSB:`SCMC_CTRL_FREQ_LSB];
        end
    end

    // Read data: unimplemented bits zero
    always_comb begin
        prdata_d = prdata_q;
        if (rd) begin
            prdata_d = 32'h0;
            case (PADDR)
                `SCMC_SYS_MODE_REG_OFS: begin
                    prdata_d[`SCMC_SYS_MODE_REG_DIV_MSB:`SCMC_SYS_MODE_REG_DIV_LSB] = clk_divide_select_q;
                    prdata_d[`SCMC_SYS_MODE_REG_SLOW_RDY] = slow_osc_ready;
                    prdata_d[`SCMC_SYS_MODE_REG_FAST_RDY] = fast_osc_ready;
                    prdata_d[`SCMC_SYS_MODE_REG_IDLE_EN] = halt_low_power_select_q;
                    prdata_d[`SCMC_SYS_MODE_REG_HIGH_SEL] = high_clk_select_q;
                end
                `SCMC_CTRL_OFS: begin
                    prdata_d[`SCMC_CTRL_KEEP_CLK] = keep_clock_in_halt_q;
                    prdata_d[`SCMC_CTRL_FREQ_MSB:`SCMC_CTRL_FREQ_LSB] = fast_rc_freq_select_q;
                end
                `SCMC_STAT_OFS: begin
                    prdata_d[3:0] = {pdf_q, to_q, mode_q};
                end
                default: begin
                    prdata_d = 32'h0;
                end
            endcase
        end
    end

    // Mode sequencing
    always_comb begin
        mode_d = mode_q;
        wdt_clr_d = 1'b0;
        pdf_d = pdf_q;
        to_d = to_q;
        if (CLR_WDT_EXEC) begin
            pdf_d = 1'b0;
            to_d = 1'b0;
        end
        case (mode_q)
            scmc_pkg::SCMC_RUN: begin
                if (HALT_EXEC) begin
                    wdt_clr_d = 1'b1;
                    pdf_d = 1'b1;
                    to_d = 1'b0;
                    if (!halt_low_power_select_q) begin
                        mode_d = scmc_pkg::SCMC_SLEEP;
                    end else if (!keep_clock_in_halt_q) begin
                        mode_d = scmc_pkg::SCMC_IDLE0;
                    end else begin
                        mode_d = scmc_pkg::SCMC_IDLE1;
                    end
                end
            end
            scmc_pkg::SCMC_SLEEP, scmc_pkg::SCMC_IDLE0, scmc_pkg::SCMC_IDLE1: begin
                if (WAKE_UP) begin
                    mode_d = scmc_pkg::SCMC_RUN;
                end
            end
            default: begin
                mode_d = scmc_pkg::SCMC_RUN;
            end
        endcase
        // Expiry set wins over software clear and halt clear
        if (WDT_EXPIRY_SET) begin
            to_d = 1'b1;
        end
    end

    // Slow ready counter restarts on wake; fast counter clears while oscillator off
    always_comb begin
        slow_cnt_d = slow_cnt_q;
        if (slow_cnt_q < `SCMC_SLOW_RDY_CYC) begin
            slow_cnt_d = slow_cnt_q + 5'd1;
        end
        if (WAKE_UP && mode_q != scmc_pkg::SCMC_RUN) begin
            slow_cnt_d = 5'd0;
        end
        fast_cnt_d = fast_cnt_q;
        if (!fast_on) begin
            fast_cnt_d = 5'd0;
        end else if (fast_cnt_q < `SCMC_FAST_RDY_CYC) begin
            fast_cnt_d = fast_cnt_q + 5'd1;
        end
    end

    // Divider restarts with the oscillator so the first tick is full length
    scmc_div #(.WIDTH(6)) u_div (
        .clk   (MCLK),
        .rst_n (RST_N),
        .run   (fast_on & fast_osc_ready),
        .tick  (tick)
    );

    // System clock enable, chosen among pulses that are each whole cycles
    always_comb begin
        sys_en_d = 1'b0;
        if (mode_q == scmc_pkg::SCMC_RUN || mode_q == scmc_pkg::SCMC_IDLE1) begin
            if (high_clk_select_q) begin
                sys_en_d = fast_osc_ready;
            end else begin
                case (clk_divide_select_q)
                    3'h2: sys_en_d = tick[5];
                    3'h3: sys_en_d = tick[4];
                    3'h4: sys_en_d = tick[3];
                    3'h5: sys_en_d = tick[2];
                    3'h6: sys_en_d = tick[1];
                    3'h7: sys_en_d = tick[0];
                    default: sys_en_d = slow_osc_ready;
                endcase
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            clk_divide_select_q <= `SCMC_SYS_MODE_REG_RST_DIV;
            high_clk_select_q <= `SCMC_SYS_MODE_REG_RST_HIGH;
            halt_low_power_select_q <= `SCMC_SYS_MODE_REG_RST_IDLE;
            keep_clock_in_halt_q <= `SCMC_CTRL_RST_KEEP;
            fast_rc_freq_select_q <= `SCMC_CTRL_RST_FREQ;
            mode_q <= scmc_pkg::SCMC_RUN;
            slow_cnt_q <= 5'd0;
            fast_cnt_q <= 5'd0;
            pdf_q <= 1'b0;
            to_q <= 1'b0;
            wdt_clr_q <= 1'b0;
            prdata_q <= 32'h0;
            sys_en_q <= 1'b0;
        end else begin
            clk_divide_select_q <= clk_divide_select_d;
            high_clk_select_q <= high_clk_select_d;
            halt_low_power_select_q <= halt_low_power_select_d;
            keep_clock_in_halt_q <= keep_clock_in_halt_d;
            fast_rc_freq_select_q <= fast_rc_freq_select_d;
            mode_q <= mode_d;
            slow_cnt_q <= slow_cnt_d;
            fast_cnt_q <= fast_cnt_d;
            pdf_q <= pdf_d;
            to_q <= to_d;
            wdt_clr_q <= wdt_clr_d;
            prdata_q <= prdata_d;
            sys_en_q <= sys_en_d;
        end
    end

    assign PRDATA = prdata_q;
    assign SYS_CLK_EN = sys_en_q;
    assign TIMEBASE_CLK_EN = (mode_q != scmc_pkg::SCMC_SLEEP);
    assign CPU_RUN = (mode_q == scmc_pkg::SCMC_RUN) & (fast_osc_ready | !fast_sel);
    assign FAST_OSC_ON = fast_on;
    assign FAST_RC_FREQ = fast_rc_freq_select_q;
    assign FAST_DIV16_EN = tick[3];
    assign FAST_DIV64_EN = tick[5];
    assign WDT_CLEAR = wdt_clr_q;
    assign POWER_DOWN_FLAG = pdf_q;
    assign WDT_EXPIRY_FLAG = to_q;

    property p_halt_sleep;
        @(posedge MCLK) disable iff (!RST_N)
        halt_go && !halt_low_power_select_q |=> mode_q == scmc_pkg::SCMC_SLEEP;
    endproperty
    a_halt_sleep: assert property (p_halt_sleep) else $error("halt did not sleep");
    property p_halt_idle0;
        @(posedge MCLK) disable iff (!RST_N)
        halt_go && halt_low_power_select_q && !keep_clock_in_halt_q
        |=> mode_q == scmc_pkg::SCMC_IDLE0;
    endproperty
    a_halt_idle0: assert property (p_halt_idle0) else $error("halt did not idle0");
    property p_halt_idle1;
        @(posedge MCLK) disable iff (!RST_N)
        halt_go && halt_low_power_select_q && keep_clock_in_halt_q
        |=> mode_q == scmc_pkg::SCMC_IDLE1;
    endproperty
    a_halt_idle1: assert property (p_halt_idle1) else $error("halt did not idle1");
    property p_halt_flags;
        @(posedge MCLK) disable iff (!RST_N)
        halt_go && !WDT_EXPIRY_SET |=> WDT_CLEAR && POWER_DOWN_FLAG && !WDT_EXPIRY_FLAG;
    endproperty
    a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");
    property p_sleep_stop;
        @(posedge MCLK) disable iff (!RST_N)
        mode_q == scmc_pkg::SCMC_SLEEP && !WAKE_UP
        |=> !SYS_CLK_EN && !TIMEBASE_CLK_EN ##0 !CPU_RUN;
    endproperty
    a_sleep_stop: assert property (p_sleep_stop) else $error("sleep clocks run");
    property p_fast_rdy;
        @(posedge MCLK) disable iff (!RST_N)
        $rose(fast_on) |-> !fast_osc_ready [*8] ##[7:9] fast_osc_ready;
    endproperty
    a_fast_rdy: assert property (p_fast_rdy) else $error("fast ready timing");
    property p_slow_off;
        @(posedge MCLK) disable iff (!RST_N)
        !fast_sel |-> !FAST_OSC_ON && !FAST_DIV16_EN && !FAST_DIV64_EN;
    endproperty
    a_slow_off: assert property (p_slow_off) else $error("fast osc left on");
    property p_div2;
        @(posedge MCLK) disable iff (!RST_N)
        mode_q == scmc_pkg::SCMC_RUN && !high_clk_select_q && clk_divide_select_q == 3'h7
        && $stable(clk_divide_select_q) && SYS_CLK_EN |=> !SYS_CLK_EN;
    endproperty
    a_div2: assert property (p_div2) else $error("div2 enable back to back");
    property p_hold;
        @(posedge MCLK) disable iff (!RST_N)
        mode_q != scmc_pkg::SCMC_RUN |=> $stable(clk_divide_select_q) && $stable(fast_rc_freq_select_q);
    endproperty
    a_hold: assert property (p_hold) else $error("state changed in halt");
    c_sleep: cover property (@(posedge MCLK) disable iff (!RST_N) halt_go ##1 mode_q == scmc_pkg::SCMC_SLEEP);
    c_idle1: cover property (@(posedge MCLK) disable iff (!RST_N) mode_q == scmc_pkg::SCMC_IDLE1 && SYS_CLK_EN);
    c_wake:  cover property (@(posedge MCLK) disable iff (!RST_N) $rose(fast_osc_ready));
endmodule : scmc_top
`default_nettype wire

// ---- scmc_cfg.svh ----
// Register map, field positions, reset values and timing counts
`ifndef SCMC_CFG_SVH
`define SCMC_CFG_SVH
`define SCMC_SYS_MODE_REG_OFS        12'h000
`define SCMC_CTRL_OFS        12'h004
`define SCMC_STAT_OFS        12'h008
`define SCMC_SYS_MODE_REG_DIV_MSB    7
`define SCMC_SYS_MODE_REG_DIV_LSB    5
`define SCMC_SYS_MODE_REG_SLOW_RDY   3
`define SCMC_SYS_MODE_REG_FAST_RDY   2
`define SCMC_SYS_MODE_REG_IDLE_EN    1
`define SCMC_SYS_MODE_REG_HIGH_SEL   0
`define SCMC_CTRL_KEEP_CLK   7
`define SCMC_CTRL_FREQ_MSB   5
`define SCMC_CTRL_FREQ_LSB   4
`define SCMC_SYS_MODE_REG_RST_DIV    3'h0
`define SCMC_SYS_MODE_REG_RST_IDLE   1'b1
`define SCMC_SYS_MODE_REG_RST_HIGH   1'b1
`define SCMC_CTRL_RST_KEEP   1'b0
`define SCMC_CTRL_RST_FREQ   2'h0
`define SCMC_SLOW_RDY_CYC    5'd2
`define SCMC_FAST_RDY_CYC    5'd16
`endif

// ---- scmc_pkg.sv ----
// Types for the system clock and mode control block
package scmc_pkg;
    typedef enum logic [1:0] {
        SCMC_RUN   = 2'b00,
        SCMC_SLEEP = 2'b01,
        SCMC_IDLE0 = 2'b10,
        SCMC_IDLE1 = 2'b11
    } scmc_mode_t;
    typedef enum logic [1:0] {
        SCMC_F8  = 2'b00,
        SCMC_F16 = 2'b01,
        SCMC_F12 = 2'b10,
        SCMC_F8B = 2'b11
    } scmc_freq_t;
endpackage : scmc_pkg

// ---- scmc_div.sv ----
// Fast clock divider producing one-cycle enable pulses
`timescale 1ns/100ps
`default_nettype none
module scmc_div #(
    parameter int WIDTH = 6
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             run,
    output logic [WIDTH-1:0]      tick
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;
    always_comb begin
        cnt_d = run ? cnt_q + {{(WIDTH-1){1'b0}}, 1'b1} : '0;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    // Tick k pulses once per 2^(k+1) cycles, always on a counter wrap, so no runt
    genvar k;
    generate
        for (k = 0; k < WIDTH; k++) begin : g_tick
            assign tick[k] = run & (&cnt_q[k:0]);
        end
    endgenerate
endmodule : scmc_div
`default_nettype wire

// ---- scmc_top_tb.sv ----
// Self-checking testbench for the system clock and mode control block
`timescale 1ns/100ps
`default_nettype none
`include "scmc_cfg.svh"
`define SCMC_TB_CHK(got, exp) \
    begin n_tests++; if ((got) !== (exp)) begin \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); n_errors++; end end
module scmc_top_tb;
    logic        MCLK = 1'b0;
    logic        RST_N = 1'b0;
    logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0;
    logic        PREADY, PSLVERR;
    logic [31:0] PRDATA, rd;
    logic        HALT_EXEC = 1'b0, WAKE_UP = 1'b0, WDT_EXPIRY_SET = 1'b0, CLR_WDT_EXEC = 1'b0;
    logic        CPU_RUN, SYS_CLK_EN, TIMEBASE_CLK_EN, FAST_OSC_ON;
    logic [1:0]  FAST_RC_FREQ;
    logic        FAST_DIV16_EN, FAST_DIV64_EN, WDT_CLEAR, POWER_DOWN_FLAG, WDT_EXPIRY_FLAG;
    int          n_errors = 0;
    int          n_tests = 0;
    int          n_sys, n_d16, n_d64;
    logic [7:0]  hsmod [3] = '{8'h01, 8'h03, 8'h03};
    logic [7:0]  hctrl [3] = '{8'h00, 8'h00, 8'h80};

    scmc_top i_dut (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .PRDATA(PRDATA), .HALT_EXEC(HALT_EXEC), .WAKE_UP(WAKE_UP), .CPU_RUN(CPU_RUN),
        .SYS_CLK_EN(SYS_CLK_EN), .TIMEBASE_CLK_EN(TIMEBASE_CLK_EN), .FAST_OSC_ON(FAST_OSC_ON),
        .FAST_RC_FREQ(FAST_RC_FREQ), .FAST_DIV16_EN(FAST_DIV16_EN),
        .FAST_DIV64_EN(FAST_DIV64_EN), .WDT_CLEAR(WDT_CLEAR),
        .POWER_DOWN_FLAG(POWER_DOWN_FLAG), .WDT_EXPIRY_FLAG(WDT_EXPIRY_FLAG),
        .WDT_EXPIRY_SET(WDT_EXPIRY_SET), .CLR_WDT_EXEC(CLR_WDT_EXEC));

    initial begin
        forever #2.5 MCLK = ~MCLK;
    end

    task automatic close_out;
        $display("Tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    // Entered just after a rising edge; held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= wd;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge MCLK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge MCLK);
    endtask : apb

    task automatic check_read(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        `SCMC_TB_CHK(rd, exp)
    endtask : check_read

    // Counts enable pulses over 128 cycles; a multiple of every divide ratio
    task automatic count_pulses;
        n_sys = 0;
        n_d16 = 0;
        n_d64 = 0;
        repeat (128) begin
            @(posedge MCLK);
            #1;
            n_sys += int'(SYS_CLK_EN === 1'b1);
            n_d16 += int'(FAST_DIV16_EN === 1'b1);
            n_d64 += int'(FAST_DIV64_EN === 1'b1);
        end
        @(posedge MCLK);
    endtask : count_pulses

    initial begin
        repeat (2) @(posedge MCLK);
        RST_N <= 1'b1;
        repeat (20) @(posedge MCLK);
        check_read(`SCMC_SYS_MODE_REG_OFS, 32'h0000000f);
        check_read(`SCMC_CTRL_OFS, 32'h00000000);
        check_read(12'h0fc, 32'h00000000);
        `SCMC_TB_CHK(PSLVERR, 1'b0)
        apb(1'b1, `SCMC_SYS_MODE_REG_OFS, 32'hffffffff);
        check_read(`SCMC_SYS_MODE_REG_OFS, 32'h000000ef);
        apb(1'b1, `SCMC_CTRL_OFS, 32'hffffffff);
        check_read(`SCMC_CTRL_OFS, 32'h000000b0);
        for (int f = 0; f < 4; f++) begin
            apb(1'b1, `SCMC_CTRL_OFS, 32'(f << 4));
            `SCMC_TB_CHK(FAST_RC_FREQ, 2'(f))
        end
        $display("Test registers done");
        for (int c = 0; c < 9; c++) begin
            apb(1'b1, `SCMC_SYS_MODE_REG_OFS, (c == 8) ? 32'h01 : 32'(c << 5));
            repeat (70) @(posedge MCLK);
            count_pulses();
            `SCMC_TB_CHK(n_sys, (c < 2 || c == 8) ? 128 : (1 << (c - 1)))
            `SCMC_TB_CHK(FAST_OSC_ON, 1'(c >= 2))
            `SCMC_TB_CHK(n_d16, (c < 2) ? 0 : 8)
            `SCMC_TB_CHK(n_d64, (c < 2) ? 0 : 2)
        end
        apb(1'b1, `SCMC_SYS_MODE_REG_OFS, 32'h00);
        repeat (20) @(posedge MCLK);
        check_read(`SCMC_SYS_MODE_REG_OFS, 32'h00000008);
        apb(1'b1, `SCMC_SYS_MODE_REG_OFS, 32'h01);
        check_read(`SCMC_SYS_MODE_REG_OFS, 32'h00000009);
        repeat (20) @(posedge MCLK);
        check_read(`SCMC_SYS_MODE_REG_OFS, 32'h0000000d);
        $display("Test clock select done");
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, `SCMC_SYS_MODE_REG_OFS, 32'(hsmod[m]));
            apb(1'b1, `SCMC_CTRL_OFS, 32'(hctrl[m]));
            repeat (20) @(posedge MCLK);
            WDT_EXPIRY_SET <= 1'b1;
            @(posedge MCLK);
            WDT_EXPIRY_SET <= 1'b0;
            HALT_EXEC <= 1'b1;
            @(posedge MCLK);
            HALT_EXEC <= 1'b0;
            #1;
            `SCMC_TB_CHK(WDT_CLEAR, 1'b1)
            `SCMC_TB_CHK(POWER_DOWN_FLAG, 1'b1)
            `SCMC_TB_CHK(WDT_EXPIRY_FLAG, 1'b0)
            repeat (3) @(posedge MCLK);
            #1;
            `SCMC_TB_CHK(WDT_CLEAR, 1'b0)
            `SCMC_TB_CHK(CPU_RUN, 1'b0)
            `SCMC_TB_CHK(SYS_CLK_EN, 1'(m == 2))
            `SCMC_TB_CHK(TIMEBASE_CLK_EN, 1'(m != 0))
            @(posedge MCLK);
            check_read(`SCMC_STAT_OFS, 32'(8 | (m + 1)));
            apb(1'b1, `SCMC_CTRL_OFS, 32'h30);
            check_read(`SCMC_CTRL_OFS, 32'(hctrl[m]));
            check_read(`SCMC_SYS_MODE_REG_OFS, 32'(hsmod[m] | 8'h08 | ((m == 2) ? 8'h04 : 8'h00)));
            WAKE_UP <= 1'b1;
            @(posedge MCLK);
            WAKE_UP <= 1'b0;
            #1;
            `SCMC_TB_CHK(CPU_RUN, 1'(m == 2))
            repeat (20) @(posedge MCLK);
            #1;
            `SCMC_TB_CHK(CPU_RUN, 1'b1)
            `SCMC_TB_CHK(POWER_DOWN_FLAG, 1'b1)
            @(posedge MCLK);
            CLR_WDT_EXEC <= 1'b1;
            @(posedge MCLK);
            CLR_WDT_EXEC <= 1'b0;
            @(posedge MCLK);
            #1;
            `SCMC_TB_CHK(POWER_DOWN_FLAG, 1'b0)
            @(posedge MCLK);
            check_read(`SCMC_STAT_OFS, 32'h0);
        end
        $display("Test halt modes done");
        close_out();
    end

    // Tests need about 2100 cycles; a hang is cut off well beyond that
    initial begin
        repeat (20000) @(posedge MCLK);
        n_errors++;
        close_out();
    end
endmodule : scmc_top_tb
`default_nettype wire
